// *** core/sflc_consts.svh ***
// constants for the synthesizer function latch control block
`ifndef SFLC_CONSTS_SVH
`define SFLC_CONSTS_SVH
`define SFLC_WORD_BITS 24
`define SFLC_SEL_LSB 0
`define SFLC_SEL_REF 2'h0
`define SFLC_SEL_AB 2'h1
`define SFLC_SEL_FUNC 2'h2
`define SFLC_SEL_INIT 2'h3
`define SFLC_CNT_RST_BIT 2
`define SFLC_PD_CTL_BIT 3
`define SFLC_MUX_LSB 4
`define SFLC_PD_POL_BIT 7
`define SFLC_CP_TRI_BIT 8
`define SFLC_SPD_EN_BIT 9
`define SFLC_SPD_VAR_BIT 10
`define SFLC_TMO_LSB 11
`define SFLC_STEADY_LSB 15
`define SFLC_FAST_LSB 18
`define SFLC_PD_SYNC_BIT 21
`define SFLC_PRE_LSB 22
`define SFLC_AB_GAIN_BIT 21
`define SFLC_FUNC_RESET 24'h00_0000
`define SFLC_PULSE_CYC 4'h4
`define SFLC_TMO_UNIT 16'h0003
`endif

// *** core/sflc_pkg.sv ***
// types for the synthesizer function latch control block
package sflc_pkg;
	typedef logic [23:0] sflc_word_t;
	typedef logic [2:0] sflc_cur_t;
	typedef enum logic [2:0] {
		SFLC_SPD_IDLE = 3'b001,
		SFLC_SPD_V1 = 3'b010,
		SFLC_SPD_V2 = 3'b100
	} sflc_spd_e;
endpackage

// *** core/sflc_tmo_rom.sv ***
// timeout lookup table: timeout code to phase detector cycles, registered read
`timescale 1ns/1ps
module sflc_tmo_rom (
	input wire logic i_clk,
	input wire logic [3:0] i_code,
	output logic [15:0] o_cycles
);
	// table is a constant so the timeout lengths can be retuned in one place
	function automatic logic [15:0] lookup(input logic [3:0] c);
		lookup = (16'({12'h000, c}) + 16'h0001) * 16'h0004 - 16'h0001;
	endfunction

	// registered read keeps the counter load off a long combinational path
	always_ff @(posedge i_clk) begin
		o_cycles <= lookup(i_code);
	end
endmodule

// *** core/sflc_top.sv ***
// function and initialization latch control of the synthesizer
`timescale 1ns/1ps
`include "sflc_consts.svh"
module sflc_top (
	input wire logic I_SYS_CLK,
	input wire logic I_RESET,
	input wire logic I_SER_CLK,
	input wire logic I_SER_DATA,
	input wire logic I_LATCH_STROBE,
	input wire logic I_CHIP_ENABLE,
	input wire logic I_PD_EVENT,
	output logic O_POWER_DOWN,
	output logic O_COUNTER_RESET,
	output logic O_CP_TRISTATE,
	output logic O_LOCK_DET_RESET,
	output sflc_pkg::sflc_cur_t O_CP_CURRENT,
	output logic O_SPEEDUP,
	output logic [1:0] O_PRESCALER_SEL,
	output logic [2:0] O_MUX_SEL,
	output logic O_PD_POLARITY,
	output sflc_pkg::sflc_word_t O_REF_WORD,
	output sflc_pkg::sflc_word_t O_AB_WORD,
	output logic O_REF_LOAD,
	output logic O_AB_LOAD
);
	import sflc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: three stages, a change counts once stages 2 and 3 agree

	logic [2:0] sck_q;
	logic [2:0] sda_q;
	logic [2:0] le_q;
	logic [2:0] ce_q;
	logic [2:0] pde_q;
	logic sck_lvl_q;
	logic le_lvl_q;
	logic ce_lvl_q;
	logic pde_lvl_q;
	logic sck_rise;
	logic le_rise;
	logic pde_rise;

	// stage 1 is only read by stage 2
	always_ff @(posedge I_SYS_CLK) begin
		sck_q <= {sck_q[1:0], I_SER_CLK};
		sda_q <= {sda_q[1:0], I_SER_DATA};
		le_q <= {le_q[1:0], I_LATCH_STROBE};
		ce_q <= {ce_q[1:0], I_CHIP_ENABLE};
		pde_q <= {pde_q[1:0], I_PD_EVENT};
	end

	// filtered levels update only when stages 2 and 3 agree
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			sck_lvl_q <= 1'b0;
			le_lvl_q <= 1'b0;
			ce_lvl_q <= 1'b0;
			pde_lvl_q <= 1'b0;
		end else begin
			if (sck_q[1] == sck_q[2]) sck_lvl_q <= sck_q[2];
			if (le_q[1] == le_q[2]) le_lvl_q <= le_q[2];
			if (ce_q[1] == ce_q[2]) ce_lvl_q <= ce_q[2];
			if (pde_q[1] == pde_q[2]) pde_lvl_q <= pde_q[2];
		end
	end

	assign sck_rise = (sck_q[1] == sck_q[2]) && sck_q[2] && !sck_lvl_q;
	assign le_rise = (le_q[1] == le_q[2]) && le_q[2] && !le_lvl_q;
	assign pde_rise = (pde_q[1] == pde_q[2]) && pde_q[2] && !pde_lvl_q;

	////////////////////////////////////////////////////////////////////////////
	// serial shift register and latch transfer

	sflc_word_t shift_q;
	sflc_word_t func_q;
	sflc_word_t ref_q;
	sflc_word_t ab_q;
	logic [1:0] sel;
	logic ld_ref;
	logic ld_ab;
	logic ld_func;
	logic ld_init;

	// shifting never stops, power-down does not gate it
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			shift_q <= '0;
		end else if (sck_rise) begin
			shift_q <= {shift_q[22:0], sda_q[2]};
		end
	end

	assign sel = shift_q[`SFLC_SEL_LSB +: 2];
	assign ld_ref = le_rise && (sel == `SFLC_SEL_REF);
	assign ld_ab = le_rise && (sel == `SFLC_SEL_AB);
	assign ld_func = le_rise && (sel == `SFLC_SEL_FUNC);
	assign ld_init = le_rise && (sel == `SFLC_SEL_INIT);

	// function and initialization latches share one layout and one store
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			func_q <= `SFLC_FUNC_RESET;
		end else if (ld_func || ld_init) begin
			func_q <= shift_q;
		end
	end

	// reference word is passed on untouched
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			ref_q <= '0;
		end else if (ld_ref) begin
			ref_q <= shift_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// function field decode

	logic cnt_rst;
	logic pd_ctl;
	logic pd_sync;
	logic spd_en;
	logic spd_var;
	logic cp_tri;
	logic [3:0] tmo_sel;

	assign cnt_rst = func_q[`SFLC_CNT_RST_BIT];
	assign pd_ctl = func_q[`SFLC_PD_CTL_BIT];
	assign pd_sync = func_q[`SFLC_PD_SYNC_BIT];
	assign spd_en = func_q[`SFLC_SPD_EN_BIT];
	assign spd_var = func_q[`SFLC_SPD_VAR_BIT];
	assign cp_tri = func_q[`SFLC_CP_TRI_BIT];
	assign tmo_sel = func_q[`SFLC_TMO_LSB +: 4];

	////////////////////////////////////////////////////////////////////////////
	// internal reset pulse after initialization and the first AB load after it

	logic ab_armed_q;
	logic [3:0] pulse_q;
	logic pulse_act;

	// arming is cleared by the first AB load, so later ones stay quiet
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			ab_armed_q <= 1'b0;
		end else if (ld_init) begin
			ab_armed_q <= 1'b1;
		end else if (ld_ab) begin
			ab_armed_q <= 1'b0;
		end
	end

	// a few cycles wide so downstream counters see it whatever their phase
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			pulse_q <= '0;
		end else if (ld_init || (ld_ab && ab_armed_q)) begin
			pulse_q <= `SFLC_PULSE_CYC;
		end else if (pulse_q != 4'h0) begin
			pulse_q <= pulse_q - 4'h1;
		end
	end

	assign pulse_act = (pulse_q != 4'h0);

	////////////////////////////////////////////////////////////////////////////
	// power-down control

	logic sync_pd_q;
	logic pd_now;

	// synchronous power-down latches on the next pump event or init pulse;
	// the init word is judged from the shifter since func_q is not loaded yet
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			sync_pd_q <= 1'b0;
		end else if (ld_init && ce_lvl_q && shift_q[`SFLC_PD_CTL_BIT]
			&& shift_q[`SFLC_PD_SYNC_BIT]) begin
			sync_pd_q <= 1'b1;
		end else if (!(pd_ctl && pd_sync)) begin
			sync_pd_q <= 1'b0;
		end else if (pde_rise) begin
			sync_pd_q <= 1'b1;
		end
	end

	// enable pin overrides both programmed modes
	assign pd_now = !ce_lvl_q
		|| (pd_ctl && !pd_sync)
		|| sync_pd_q;

	////////////////////////////////////////////////////////////////////////////
	// speedup state and AB latch with self-clearing gain bit

	sflc_spd_e spd_q;
	logic [15:0] tmo_len;
	logic [15:0] tmo_cnt_q;
	logic [15:0] unit_q;
	logic tmo_done;
	logic gain;

	sflc_tmo_rom u_rom (
		.i_clk(I_SYS_CLK),
		.i_code(tmo_sel),
		.o_cycles(tmo_len)
	);

	assign gain = ab_q[`SFLC_AB_GAIN_BIT];
	assign tmo_done = (spd_q == SFLC_SPD_V2) && (tmo_cnt_q == 16'h0000)
		&& (unit_q == 16'h0000);

	// timeout clears the gain bit; a fresh AB write in the same cycle wins
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			ab_q <= '0;
		end else if (ld_ab) begin
			ab_q <= shift_q;
		end else if (tmo_done) begin
			ab_q[`SFLC_AB_GAIN_BIT] <= 1'b0;
		end
	end

	// speedup mode follows enable, variant and the gain bit
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			spd_q <= SFLC_SPD_IDLE;
		end else if (!spd_en || !gain || tmo_done) begin
			spd_q <= SFLC_SPD_IDLE;
		end else begin
			spd_q <= spd_var ? SFLC_SPD_V2 : SFLC_SPD_V1;
		end
	end

	// one phase detector cycle approximated by a fixed system-clock prescale
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET || spd_q != SFLC_SPD_V2 || pd_now || pulse_act) begin
			unit_q <= `SFLC_TMO_UNIT;
		end else if (unit_q == 16'h0000) begin
			unit_q <= `SFLC_TMO_UNIT;
		end else begin
			unit_q <= unit_q - 16'h0001;
		end
	end

	// counter sits at load state unless variant two is running
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET || spd_q != SFLC_SPD_V2 || pd_now || pulse_act) begin
			tmo_cnt_q <= tmo_len;
		end else if (unit_q == 16'h0000 && tmo_cnt_q != 16'h0000) begin
			tmo_cnt_q <= tmo_cnt_q - 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registered outputs

	// counters held while reset bit, power-down or pulse; release aligns them
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			O_POWER_DOWN <= 1'b1;
			O_COUNTER_RESET <= 1'b1;
			O_CP_TRISTATE <= 1'b1;
			O_LOCK_DET_RESET <= 1'b1;
		end else begin
			O_POWER_DOWN <= pd_now;
			O_COUNTER_RESET <= cnt_rst || pd_now || pulse_act;
			O_CP_TRISTATE <= cp_tri || pd_now || pulse_act || cnt_rst;
			O_LOCK_DET_RESET <= pd_now;
		end
	end

	// pump current picks fast setting only while speedup is live
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			O_CP_CURRENT <= '0;
			O_SPEEDUP <= 1'b0;
		end else if (spd_q != SFLC_SPD_IDLE) begin
			O_CP_CURRENT <= func_q[`SFLC_FAST_LSB +: 3];
			O_SPEEDUP <= 1'b1;
		end else begin
			O_CP_CURRENT <= func_q[`SFLC_STEADY_LSB +: 3];
			O_SPEEDUP <= 1'b0;
		end
	end

	// plain configuration fields and the other latches
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			O_PRESCALER_SEL <= '0;
			O_MUX_SEL <= '0;
			O_PD_POLARITY <= 1'b0;
			O_REF_WORD <= '0;
			O_AB_WORD <= '0;
			O_REF_LOAD <= 1'b0;
			O_AB_LOAD <= 1'b0;
		end else begin
			O_PRESCALER_SEL <= func_q[`SFLC_PRE_LSB +: 2];
			O_MUX_SEL <= func_q[`SFLC_MUX_LSB +: 3];
			O_PD_POLARITY <= func_q[`SFLC_PD_POL_BIT];
			O_REF_WORD <= ref_q;
			O_AB_WORD <= ab_q;
			O_REF_LOAD <= ld_ref;
			O_AB_LOAD <= ld_ab;
		end
	end
endmodule

// *** dv/sflc_top_properties.sv ***
// assertion checker for the synthesizer latch control ports
`timescale 1ns/1ps
`include "sflc_consts.svh"
module sflc_chk (
	input wire logic I_SYS_CLK,
	input wire logic I_RESET,
	input wire logic I_CHIP_ENABLE,
	input wire logic O_POWER_DOWN,
	input wire logic O_COUNTER_RESET,
	input wire logic O_CP_TRISTATE,
	input wire logic O_LOCK_DET_RESET,
	input wire logic O_SPEEDUP,
	input wire sflc_pkg::sflc_word_t O_REF_WORD,
	input wire sflc_pkg::sflc_word_t O_AB_WORD,
	input wire logic O_REF_LOAD,
	input wire logic O_AB_LOAD
);
	import sflc_pkg::*;
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RESET);
	////////////////////////////////////////////////////////////////////////////////
	// enable pin goes through a sync chain and an output flop, so allow six cycles
	chk_ce_disable: assert property (!I_CHIP_ENABLE [*6] |-> O_POWER_DOWN)
		else $error("enable low without power-down");
	chk_pd_effects: assert property (O_POWER_DOWN |-> ##[0:1]
		(O_CP_TRISTATE && O_COUNTER_RESET && O_LOCK_DET_RESET)) else $error("pd effects missing");
	chk_gain_speed: assert property (!O_AB_WORD[21] [*2] |-> !O_SPEEDUP)
		else $error("speedup without gain bit");
	chk_ab_pulse: assert property (O_AB_LOAD |=> !O_AB_LOAD)
		else $error("ab load pulse too long");
	chk_ref_sel: assert property (O_REF_LOAD |-> ##[0:1] O_REF_WORD[1:0] == `SFLC_SEL_REF)
		else $error("ref word with wrong select");
	chk_ab_sel: assert property (O_AB_LOAD |-> ##[0:1] O_AB_WORD[1:0] == `SFLC_SEL_AB)
		else $error("ab word with wrong select");
	chk_ref_hold: assert property ($changed(O_REF_WORD) |-> O_REF_LOAD || $past(O_REF_LOAD))
		else $error("ref word changed without load");
	chk_ab_hold: assert property ($changed(O_AB_WORD) && !O_AB_LOAD && !$past(O_AB_LOAD)
		|-> $fell(O_AB_WORD[21])) else $error("ab word changed without cause");
	chk_crst_tri: assert property (O_COUNTER_RESET |-> O_CP_TRISTATE)
		else $error("counter reset without three-state");
endmodule
bind sflc_top sflc_chk i_chk (.I_SYS_CLK, .I_RESET, .I_CHIP_ENABLE, .O_POWER_DOWN,
	.O_COUNTER_RESET, .O_CP_TRISTATE, .O_LOCK_DET_RESET, .O_SPEEDUP, .O_REF_WORD,
	.O_AB_WORD, .O_REF_LOAD, .O_AB_LOAD);

// *** dv/sflc_host_model.sv ***
// host model driving the three-wire serial port
`timescale 1ns/1ps
module sflc_host (
	input wire logic i_clk,
	output logic o_sck,
	output logic o_data,
	output logic o_le
);
	// serial clock stands still low between frames
	initial begin
		o_sck = 0;
		o_data = 0;
		o_le = 0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	// msb first, 80 ns bit time, strobe raised only after the 24th bit
	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			o_data = w[i];
			hold(5);
			o_sck = 1;
			hold(5);
			o_sck = 0;
		end
		o_data = ~o_data; // released line must not keep its last value
		o_le = 1;
		hold(2);
		o_le = 0;
		hold(8);
	endtask
endmodule

// *** dv/test_synth_function_latch_control.sv ***
// self-checking bench for the synthesizer latch control block
`timescale 1ns/1ps
`include "sflc_consts.svh"
module test_synth_function_latch_control;
	import sflc_pkg::*;
	logic clk, rst, ce, pde, sck, sda, le, pd, crst, tri_s, ldr, spd, rl, al, pol;
	sflc_cur_t cur;
	logic [1:0] pre;
	logic [2:0] mux;
	sflc_word_t rw_o, aw_o;
	int errors, n_tests, n_crst, n_spd, seed, e;
	logic [23:0] base, fw, rw, aw;
	sflc_top i_dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_SER_CLK(sck), .I_SER_DATA(sda),
		.I_LATCH_STROBE(le), .I_CHIP_ENABLE(ce), .I_PD_EVENT(pde), .O_POWER_DOWN(pd),
		.O_COUNTER_RESET(crst), .O_CP_TRISTATE(tri_s), .O_LOCK_DET_RESET(ldr),
		.O_CP_CURRENT(cur), .O_SPEEDUP(spd), .O_PRESCALER_SEL(pre), .O_MUX_SEL(mux),
		.O_PD_POLARITY(pol), .O_REF_WORD(rw_o), .O_AB_WORD(aw_o), .O_REF_LOAD(rl),
		.O_AB_LOAD(al));
	sflc_host i_host (.i_clk(clk), .o_sck(sck), .o_data(sda), .o_le(le));
	////////////////////////////////////////////////////////////////////////////////
	// 125 MHz clock
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// pulse and speedup lengths are measured, not sampled once
	always @(posedge clk) begin
		if (crst === 1'b1) n_crst++;
		if (spd === 1'b1) n_spd++;
	end
	task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmpb(input logic got, input logic exp);
		cmp({23'h0, got}, {23'h0, exp});
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// send one word and update the reference model by its select bits
	task automatic put(input logic [23:0] w);
		n_crst = 0;
		i_host.send(w);
		case (w[1:0])
			2'h0: rw = w;
			2'h1: aw = w & 24'hDF_FFFF; // base AB word keeps gain low; scenarios set it per call
			default: fw = w;
		endcase
		if (w[1:0] == 2'h0) cmp(rw_o, w);
		if (w[1:0] == 2'h1 && !w[21]) cmp(aw_o, w);
	endtask
	task automatic fields(input logic fast);
		cmp(24'({pre, mux, pol, cur}), 24'({fw[23:22], fw[6:4], fw[7],
			fast ? fw[20:18] : fw[17:15]}));
	endtask
	function automatic logic [23:0] fn(input logic [23:0] b);
		return base | b | 24'h00_0002;
	endfunction
	// watchdog well past the expected run length
	initial begin
		#300_000;
		errors++;
		stop_test();
	end
	// main sequence
	initial begin
		seed = 46;
		errors = 0;
		n_tests = 0;
		rst = 1;
		ce = 0;
		pde = 0;
		base = 24'($random(seed)) & 24'hDF_80F0; // random prescaler kept legal
		base[20:18] = ~base[17:15];
		rw = 24'($random(seed)) & 24'hFF_FFFC;
		aw = (24'($random(seed)) & 24'hDF_FFFC) | 24'h00_0001;
		cyc(4);
		rst = 0;
		ce = 1;
		cyc(6);
		put(fn(24'h00_0001)); // init, function, ref, AB order
		cmp(24'(n_crst), 24'(`SFLC_PULSE_CYC));
		fields(0);
		put(fn(0));
		put(rw);
		put(aw);
		cmp(24'(n_crst), 24'(`SFLC_PULSE_CYC));
		put(aw ^ 24'h00_0F00);
		cmp(24'(n_crst), 24'h0);
		put(fn(24'h00_0004));
		cmpb(crst, 1);
		put(fn(0));
		cmpb(crst, 0);
		put(fn(24'h00_0100));
		cmpb(tri_s, 1);
		put(fn(0));
		cmpb(tri_s, 0);
		put(fn(24'h00_0008));
		cmpb(pd, 1);
		put(rw ^ 24'h01_2340);
		put(fn(24'h20_0008));
		cmpb(pd, 0);
		pde = 1;
		cyc(8);
		pde = 0;
		cyc(8);
		cmpb(pd, 1);
		put(fn(0));
		ce = 0;
		cyc(6); // three sync stages, level filter and output flop
		cmpb(ldr, 1);
		put(rw); // program while disabled
		put(aw);
		ce = 1;
		cyc(6);
		cmpb(pd, 0);
		fields(0);
		put(aw | 24'h20_0000);
		cmpb(spd, 0);
		put(aw);
		put(fn(24'h00_0200));
		put(aw | 24'h20_0000);
		cmpb(spd, 1);
		fields(1);
		cyc(300);
		cmpb(spd, 1);
		put(aw);
		cmpb(spd, 0);
		fields(0);
		for (int t = 0; t < 16; t += 15) begin
			put(fn(24'h00_0600 | 24'(t << 11)));
			n_spd = 0;
			put(aw | 24'h20_0000);
			for (int k = 0; k < 400 && spd !== 1'b0; k++) cyc(1);
			e = ((t + 1) * 4 - 1) * 4;
			cmpb(n_spd >= e - 2 && n_spd <= e + 6, 1);
			cmpb(aw_o[21], 0);
		end
		put(fn(24'h20_0008) | 24'h00_0001);
		cmpb(pd, 1);
		stop_test();
	end
endmodule
